// [core/dgmad_pkg.sv]
// constants shared by the datagram address decoder files
// assumes a 40 MHz system clock and a 32-bit serial datagram link
package dgmad_pkg;
    // datagram layout, msb first on the wire
    localparam int DG_BITS = 32;
    localparam int HDR_BITS = 8;
    localparam int DATA_W = 24;
    localparam int STATUS_W = 8;
    localparam int ADDR_W = 6;
    localparam int BIT_SPACE = 31;
    localparam int BIT_ADDR_HI = 30;
    localparam int BIT_ADDR_LO = 25;
    localparam int BIT_RW = 24;
    localparam logic SPACE_REG = 1'b0;
    localparam logic SPACE_RAM = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // register space: upper two address bits pick the block
    localparam logic [1:0] BLK_MOTOR1 = 2'h0;
    localparam logic [1:0] BLK_MOTOR2 = 2'h1;
    localparam logic [1:0] BLK_MOTOR3 = 2'h2;
    localparam logic [1:0] BLK_COMMON = 2'h3;
    localparam logic [5:0] GLOBAL_ADDR = 6'h3F;
    localparam int REG_COUNT = 64;

    // global parameter register fields
    localparam int PREDIV_LSB = 8;
    localparam int PREDIV_W = 8;
    localparam logic [7:0] PREDIV_RST = 8'h0F;
    localparam logic [23:0] REG_RST = 24'h000000;
    localparam logic [23:0] GLOBAL_RST = {8'h00, PREDIV_RST, 8'h00};

    // ram: 128 words of 6 bits, written in pairs
    localparam int RAM_WORDS = 128;
    localparam int RAM_WORD_W = 6;
    localparam int RAM_LO_LSB = 0;
    localparam int RAM_HI_LSB = 8;

    // internal initialisation time after reset
    localparam int CLK_PERIOD_NS = 25;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // axi4-lite map
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] AXI_CTRL = 8'h00;
    localparam logic [7:0] AXI_STATUS = 8'h04;
    localparam logic [7:0] AXI_LAST_HDR = 8'h08;
    localparam logic [7:0] AXI_COUNTS = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h00000001;
    localparam int CTRL_CHAIN_EN = 0;
    localparam int CTRL_LINK_LOCK = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/dgmad_link.sv]
// serial datagram shifter: samples the host link and shifts the reply out
// assumes sck idles low, host changes sdi on falling and samples on rising edges
module dgmad_link import dgmad_pkg::*; (
    input wire logic i_clk_sys, // system clock
    input wire logic i_sys_rst, // async reset, high
    input wire logic i_scs_n, // link chip select, low active, raw pin
    input wire logic i_sck, // link clock, raw pin
    input wire logic i_sdi, // link data in, raw pin
    input wire logic [STATUS_W-1:0] i_status, // status byte for the reply
    input wire logic i_rd_load, // read data valid, one cycle
    input wire logic [DATA_W-1:0] i_rd_data, // read data for the reply
    output logic o_hdr_valid, // first eight bits received, pulse
    output logic [HDR_BITS-1:0] o_hdr, // space, address, rw
    output logic o_frame_done, // full datagram received, pulse
    output logic [DG_BITS-1:0] o_frame, // received datagram
    output logic o_sdo // link data out
);
    logic scs_m, scs_s, scs_d;
    logic sck_m, sck_s, sck_d;
    logic sdi_m, sdi_s;
    logic [5:0] bit_cnt;
    logic [DG_BITS-1:0] rx;
    logic [DG_BITS-1:0] tx;
    logic cs_fall, cs_rise, sck_rise, sck_fall;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {scs_m, scs_s, scs_d} <= 3'h7;
            {sck_m, sck_s, sck_d} <= 3'h0;
            {sdi_m, sdi_s} <= 2'h0;
        end else begin
            scs_m <= i_scs_n;
            scs_s <= scs_m;
            scs_d <= scs_s;
            sck_m <= i_sck;
            sck_s <= sck_m;
            sck_d <= sck_s;
            sdi_m <= i_sdi;
            sdi_s <= sdi_m;
        end
    end

    assign cs_fall = scs_d & ~scs_s;
    assign cs_rise = ~scs_d & scs_s;
    assign sck_rise = sck_s & ~sck_d & ~scs_s;
    assign sck_fall = ~sck_s & sck_d & ~scs_s;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx <= '0;
            bit_cnt <= 6'h00;
        end else if (cs_fall) begin
            rx <= '0;
            bit_cnt <= 6'h00;
        end else if (sck_rise && bit_cnt < 6'(DG_BITS)) begin
            rx <= {rx[DG_BITS-2:0], sdi_s};
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // address space is known after the first eight bits
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hdr_valid <= 1'b0;
            o_hdr <= '0;
        end else begin
            o_hdr_valid <= sck_rise && bit_cnt == 6'(HDR_BITS - 1);
            o_hdr <= {rx[HDR_BITS-2:0], sdi_s};
        end
    end

    // short frames are dropped, never committed; long frames commit their first 32 bits
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_frame_done <= 1'b0;
            o_frame <= '0;
        end else begin
            o_frame_done <= cs_rise && bit_cnt == 6'(DG_BITS);
            o_frame <= rx;
        end
    end

    // read data lands in tx[30:7], behind the eight status bits already sent, before the eighth falling edge
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx <= '0;
            o_sdo <= 1'b0;
        end else if (scs_s) begin
            tx <= '0;
            o_sdo <= i_status[STATUS_W-1]; // idle pin carries the interrupt level
        end else if (cs_fall) begin
            tx <= {i_status, {DATA_W{1'b0}}};
            o_sdo <= i_status[STATUS_W-1];
        end else if (i_rd_load) begin
            tx[DG_BITS-2:DG_BITS-1-DATA_W] <= i_rd_data;
        end else if (sck_fall) begin
            tx <= {tx[DG_BITS-2:0], 1'b0};
            o_sdo <= tx[DG_BITS-2];
        end
    end
endmodule

// [core/dgmad_axil.sv]
// axi4-lite slave for the decoder's own control and status words
// assumes a single outstanding write and read, as axi4-lite masters do
module dgmad_axil import dgmad_pkg::*; (
    input wire logic i_clk_sys, // system clock
    input wire logic i_sys_rst, // async reset, high
    input wire logic [AXI_ADDR_W-1:0] i_awaddr, // write address
    input wire logic i_awvalid, // write address valid
    output logic o_awready, // write address ready
    input wire logic [31:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // byte enables
    input wire logic i_wvalid, // write data valid
    output logic o_wready, // write data ready
    output logic [1:0] o_bresp, // write response
    output logic o_bvalid, // write response valid
    input wire logic i_bready, // write response ready
    input wire logic [AXI_ADDR_W-1:0] i_araddr, // read address
    input wire logic i_arvalid, // read address valid
    output logic o_arready, // read address ready
    output logic [31:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    output logic o_rvalid, // read data valid
    input wire logic i_rready, // read data ready
    input wire logic [31:0] i_status_word, // live status
    input wire logic [31:0] i_last_word, // last header seen
    input wire logic [31:0] i_count_word, // datagram counters
    output logic [31:0] o_ctrl // control word
);
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            o_ctrl <= CTRL_RST;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (!o_awready && !o_wready && !o_bvalid) begin
                o_bvalid <= 1'b1;
                o_bresp <= RESP_SLVERR;
                if (aw_addr == AXI_CTRL) begin
                    o_bresp <= RESP_OKAY;
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb[b]) begin
                            o_ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
                        end
                    end
                end else if (aw_addr == AXI_STATUS || aw_addr == AXI_LAST_HDR
                             || aw_addr == AXI_COUNTS) begin
                    o_bresp <= RESP_OKAY; // read-only words ignore writes
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= RESP_OKAY;
            case (i_araddr)
                AXI_CTRL: o_rdata <= o_ctrl;
                AXI_STATUS: o_rdata <= i_status_word;
                AXI_LAST_HDR: o_rdata <= i_last_word;
                AXI_COUNTS: o_rdata <= i_count_word;
                default: begin
                    o_rdata <= '0;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end
endmodule

// [core/dgmad_top.sv]
// datagram address decoder: register set, pair-written ram and reply data
// assumes the serial link pins arrive unsynchronised; axi4-lite on i_clk_sys
module dgmad_top import dgmad_pkg::*; #(
    parameter logic [REG_COUNT-1:0] REG_USED = {REG_COUNT{1'b1}}, // decoded addresses
    parameter logic [REG_COUNT-1:0] REG_RO = {REG_COUNT{1'b0}}, // read-only addresses
    parameter logic [REG_COUNT-1:0] REG_FX = {REG_COUNT{1'b0}} // ro writes with side effect
) (
    input wire logic i_clk_sys, // system clock, 40 MHz
    input wire logic i_sys_rst, // async reset, high
    input wire logic i_scs_n, // link chip select, low active
    input wire logic i_sck, // link clock
    input wire logic i_sdi, // link data from host
    output logic o_sdo, // link data to host
    input wire logic [STATUS_W-1:0] i_status_bits, // status byte from the core
    output logic o_wr_pulse, // register written, one cycle
    output logic [1:0] o_wr_block, // block of the written register
    output logic [3:0] o_wr_index, // register_index within the block
    output logic [DATA_W-1:0] o_wr_data, // value written
    output logic o_fx_pulse, // side-effect write, one cycle
    output logic [ADDR_W-1:0] o_fx_addr, // address of the side-effect write
    output logic [DATA_W-1:0] o_fx_data, // data of the side-effect write
    output logic o_init_busy, // internal initialisation running
    output logic o_chain_send_en, // driver chain may send datagrams
    output logic [PREDIV_W-1:0] o_serial_clock_predivider, // chain clock divider
    input wire logic [ADDR_W-1:0] i_peek_addr, // core read port address
    output logic [DATA_W-1:0] o_peek_data, // core read port data
    input wire logic [6:0] i_ram_addr, // core ram read address
    output logic [RAM_WORD_W-1:0] o_ram_data, // core ram read data
    input wire logic [AXI_ADDR_W-1:0] i_awaddr, // axi write address
    input wire logic i_awvalid, // axi write address valid
    output logic o_awready, // axi write address ready
    input wire logic [31:0] i_wdata, // axi write data
    input wire logic [3:0] i_wstrb, // axi byte enables
    input wire logic i_wvalid, // axi write data valid
    output logic o_wready, // axi write data ready
    output logic [1:0] o_bresp, // axi write response
    output logic o_bvalid, // axi write response valid
    input wire logic i_bready, // axi write response ready
    input wire logic [AXI_ADDR_W-1:0] i_araddr, // axi read address
    input wire logic i_arvalid, // axi read address valid
    output logic o_arready, // axi read address ready
    output logic [31:0] o_rdata, // axi read data
    output logic [1:0] o_rresp, // axi read response
    output logic o_rvalid, // axi read valid
    input wire logic i_rready // axi read ready
);
    logic [DATA_W-1:0] reg_file [0:REG_COUNT-1];
    logic [RAM_WORD_W-1:0] ram [0:RAM_WORDS-1];
    logic hdr_valid;
    logic [HDR_BITS-1:0] hdr;
    logic frame_done;
    logic [DG_BITS-1:0] frame;
    logic rd_load;
    logic [DATA_W-1:0] rd_data;
    logic [15:0] init_cnt;
    logic [31:0] ctrl;
    logic [HDR_BITS-1:0] last_hdr;
    logic [15:0] frame_cnt;
    logic [15:0] ignored_cnt;
    logic f_space;
    logic [ADDR_W-1:0] f_addr;
    logic f_rw;
    logic [DATA_W-1:0] f_data;
    logic link_write;
    logic reg_write;

    function automatic logic addr_used(input logic [ADDR_W-1:0] a);
        return REG_USED[a];
    endfunction

    function automatic logic addr_writable(input logic [ADDR_W-1:0] a);
        return REG_USED[a] && !REG_RO[a];
    endfunction

    function automatic logic [DATA_W-1:0] ram_pair(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        v[RAM_LO_LSB +: RAM_WORD_W] = ram[{a, 1'b0}];
        v[RAM_HI_LSB +: RAM_WORD_W] = ram[{a, 1'b1}];
        return v;
    endfunction

    dgmad_link u_link (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_scs_n(i_scs_n),
        .i_sck(i_sck),
        .i_sdi(i_sdi),
        .i_status(i_status_bits),
        .i_rd_load(rd_load),
        .i_rd_data(rd_data),
        .o_hdr_valid(hdr_valid),
        .o_hdr(hdr),
        .o_frame_done(frame_done),
        .o_frame(frame),
        .o_sdo(o_sdo)
    );

    assign f_space = frame[BIT_SPACE];
    assign f_addr = frame[BIT_ADDR_HI:BIT_ADDR_LO];
    assign f_rw = frame[BIT_RW];
    assign f_data = frame[DATA_W-1:0];
    // writes are dropped during init and while software holds the link lock
    assign link_write = frame_done && f_rw == RW_WRITE && !o_init_busy
                        && !ctrl[CTRL_LINK_LOCK];
    assign reg_write = link_write && f_space == SPACE_REG && addr_writable(f_addr);

    // init timer; the register file itself is loaded with its reset values by the reset
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            init_cnt <= 16'h0000;
            o_init_busy <= 1'b1;
        end else if (o_init_busy) begin
            init_cnt <= init_cnt + 16'h0001;
            o_init_busy <= init_cnt != 16'(INIT_CYCLES - 1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_chain_send_en <= 1'b0;
        end else begin
            o_chain_send_en <= !o_init_busy && ctrl[CTRL_CHAIN_EN];
        end
    end

    // register set; reset is the internal initialisation
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                reg_file[i] <= (i == int'(GLOBAL_ADDR)) ? GLOBAL_RST : REG_RST;
            end
        end else if (reg_write) begin
            reg_file[f_addr] <= f_data;
        end
    end

    // ram has no reset on purpose: contents come from the host
    always_ff @(posedge i_clk_sys) begin
        if (link_write && f_space == SPACE_RAM) begin
            ram[{f_addr, 1'b0}] <= f_data[RAM_LO_LSB +: RAM_WORD_W];
            ram[{f_addr, 1'b1}] <= f_data[RAM_HI_LSB +: RAM_WORD_W];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_serial_clock_predivider <= PREDIV_RST;
        end else begin
            o_serial_clock_predivider <= reg_file[GLOBAL_ADDR][PREDIV_LSB +: PREDIV_W];
        end
    end

    // write notification to the motion logic, block and index split
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wr_pulse <= 1'b0;
            o_wr_block <= BLK_MOTOR1;
            o_wr_index <= 4'h0;
            o_wr_data <= '0;
        end else begin
            o_wr_pulse <= reg_write;
            if (reg_write) begin
                o_wr_block <= f_addr[5:4];
                o_wr_index <= f_addr[3:0];
                o_wr_data <= f_data;
            end
        end
    end

    // read-only addresses: data is dropped; the side effect fires only where REG_FX is set
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fx_pulse <= 1'b0;
            o_fx_addr <= '0;
            o_fx_data <= '0;
        end else begin
            o_fx_pulse <= link_write && f_space == SPACE_REG && REG_FX[f_addr]
                          && addr_used(f_addr) && REG_RO[f_addr];
            o_fx_addr <= f_addr;
            o_fx_data <= f_data;
        end
    end

    // reply data is fetched once the header is in, for reads and writes alike
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_load <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_load <= hdr_valid;
            if (hdr_valid) begin
                if (o_init_busy) begin
                    rd_data <= '0;
                end else if (hdr[HDR_BITS-1] == SPACE_RAM) begin
                    rd_data <= ram_pair(hdr[HDR_BITS-2:1]);
                end else if (addr_used(hdr[HDR_BITS-2:1])) begin
                    rd_data <= reg_file[hdr[HDR_BITS-2:1]];
                end else begin
                    rd_data <= '0;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_peek_data <= '0;
            o_ram_data <= '0;
        end else begin
            o_peek_data <= reg_file[i_peek_addr];
            o_ram_data <= ram[i_ram_addr];
        end
    end

    // bookkeeping for software; counters wrap
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            last_hdr <= '0;
            frame_cnt <= 16'h0000;
            ignored_cnt <= 16'h0000;
        end else begin
            if (hdr_valid) begin
                last_hdr <= hdr;
            end
            if (frame_done) begin
                frame_cnt <= frame_cnt + 16'h0001;
            end
            if (frame_done && f_space == SPACE_REG && !addr_used(f_addr)) begin
                ignored_cnt <= ignored_cnt + 16'h0001;
            end
        end
    end

    dgmad_axil u_axil (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .i_status_word({14'h0000, o_chain_send_en, o_init_busy,
                        o_serial_clock_predivider, i_status_bits}),
        .i_last_word({24'h000000, last_hdr}),
        .i_count_word({ignored_cnt, frame_cnt}),
        .o_ctrl(ctrl)
    );
endmodule

// [test/dgmad_asserts.sv]
// checker on the decoder top ports: init timing, write gating, axi answers
// assumes binding to dgmad_top with matching port names
module dgmad_asserts import dgmad_pkg::*; (
    input wire logic i_clk_sys, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_scs_n, // link select
    input wire logic o_wr_pulse, // write pulse
    input wire logic [1:0] o_wr_block, // block
    input wire logic [3:0] o_wr_index, // index
    input wire logic [DATA_W-1:0] o_wr_data, // data
    input wire logic o_fx_pulse, // side effect
    input wire logic o_init_busy, // init
    input wire logic o_chain_send_en, // chain enable
    input wire logic [PREDIV_W-1:0] o_serial_clock_predivider, // divider
    input wire logic i_awvalid, // aw valid
    input wire logic o_awready, // aw ready
    input wire logic i_wvalid, // w valid
    input wire logic o_wready, // w ready
    input wire logic o_bvalid, // b valid
    input wire logic i_arvalid, // ar valid
    input wire logic o_arready, // ar ready
    input wire logic o_rvalid // r valid
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // saturating count of cycles since reset release
    logic [5:0] cyc;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cyc <= 6'h00;
        end else if (cyc != 6'h3F) begin
            cyc <= cyc + 6'h01;
        end
    end
    chk_init_len: assert property (o_init_busy == (int'(cyc) < INIT_CYCLES))
        else $error("init busy length wrong");
    chk_send_gate: assert property (o_init_busy |=> !o_chain_send_en)
        else $error("chain enabled during init");
    chk_pred_reset: assert property (cyc == 6'h00
        |-> o_serial_clock_predivider == PREDIV_RST) else $error("predivider reset value wrong");
    chk_pred_write: assert property (o_wr_pulse && {o_wr_block, o_wr_index} == GLOBAL_ADDR
        |-> ##[1:2] o_serial_clock_predivider == o_wr_data[15:8])
        else $error("predivider not set");
    chk_wr_gate: assert property (o_wr_pulse |-> !o_init_busy && i_scs_n)
        else $error("write pulse during init or frame");
    chk_fx_only: assert property (o_fx_pulse |-> !o_wr_pulse)
        else $error("read-only write stored");
    chk_axi_bresp: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("no write response");
    chk_axi_rresp: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("no read response");
    cover property (o_wr_pulse);
    cover property (o_fx_pulse);
    cover property (o_rvalid);
endmodule
bind dgmad_top dgmad_asserts u_chk (.*);

// [test/dgmad_host.sv]
// host side of the serial datagram link: full duplex 32-bit exchange
// assumes sck period of 8 system clocks, idles low outside frames
module dgmad_host (
    input wire logic i_clk, // system clock
    input wire logic i_sdo, // reply from device
    output logic o_scs_n, // select, low active
    output logic o_sck, // link clock
    output logic o_sdi // datagram to device
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scs_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b1;
    end
    // whole word per frame, so packed fields always move together
    task automatic xfer(input logic [31:0] f, output logic [31:0] r);
        @(posedge i_clk);
        o_scs_n <= 1'b0;
        o_sdi <= f[31];
        repeat (4) @(posedge i_clk);
        for (int i = 31; i >= 0; i--) begin
            o_sck <= 1'b1;
            r[i] = i_sdo;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b0;
            // released line shows the inverse, never a stale value
            o_sdi <= (i > 0) ? f[(i + 31) % 32] : !f[0];
            repeat (4) @(posedge i_clk);
        end
        o_scs_n <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// [test/testbench.sv]
// self-checking bench for dgmad_top: serial datagrams plus axi4-lite words
// assumes 40 MHz clock; 0x3E read-only with side effect, 0x3D unused
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dgmad_pkg::*;
    logic i_clk_sys, i_sys_rst = 1'b1, i_scs_n, i_sck, i_sdi, o_sdo;
    logic [7:0] i_status_bits = 8'h95, i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rep;
    logic [3:0] i_wstrb = 4'hF, o_wr_index;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wr_pulse, o_fx_pulse;
    logic o_init_busy, o_chain_send_en;
    logic [1:0] o_bresp, o_rresp, o_wr_block;
    logic [23:0] o_wr_data, o_fx_data, o_peek_data;
    logic [5:0] o_fx_addr, i_peek_addr = 6'h00, o_ram_data;
    logic [6:0] i_ram_addr = 7'h00;
    logic [7:0] o_serial_clock_predivider;
    int n_fail, n_checks, n_wr, n_fx;
    dgmad_top #(.REG_USED(64'hDFFFFFFFFFFFFFFF), .REG_RO(64'h4000000000000000),
        .REG_FX(64'h4000000000000000)) dut (.*);
    dgmad_host u_host (.i_clk(i_clk_sys), .i_sdo(o_sdo), .o_scs_n(i_scs_n), .o_sck(i_sck),
        .o_sdi(i_sdi));
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        if (o_wr_pulse === 1'b1) n_wr++;
        if (o_fx_pulse === 1'b1) n_fx++;
    end
    task conclude();
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        forever begin
            @(posedge i_clk_sys);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        i_bready <= 1'b0;
        chk(o_bresp, er);
    endtask
    task axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        forever begin
            @(posedge i_clk_sys);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        i_rready <= 1'b0;
        chk({o_rdata[31:2], o_rresp}, {ed[31:2], er});
        chk(o_rdata[1:0], ed[1:0]);
    endtask
    task lf(logic [31:0] f, logic [23:0] old);
        u_host.xfer(f, rep);
        chk(rep, {i_status_bits, old});
    endtask
    task peek(logic [5:0] a, logic [23:0] e);
        @(posedge i_clk_sys);
        i_peek_addr <= a;
        i_ram_addr <= {1'b1, a};
        repeat (2) @(posedge i_clk_sys);
        chk(o_peek_data, e);
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        peek(GLOBAL_ADDR, 24'h000F00);
        peek(6'h00, 24'h000000);
        while (o_init_busy !== 1'b0) @(posedge i_clk_sys);
        axr(AXI_STATUS, 32'h00020F95, RESP_OKAY);
        axr(8'h10, 32'h0, RESP_SLVERR);
        axw(8'h10, 32'h1, RESP_SLVERR);
        // ram holds unknowns until loaded, so this reply is not compared
        u_host.xfer({SPACE_RAM, 6'h3F, RW_WRITE, 24'h002321}, rep);
        peek(6'h3E, 24'h000000);
        chk(o_ram_data, 6'h21);
        peek(6'h3F, 24'h000F00);
        chk(o_ram_data, 6'h23);
        lf({SPACE_RAM, 6'h3F, RW_READ, 24'h0}, 24'h002321);
        lf({SPACE_REG, 6'h19, RW_WRITE, 24'h000123}, 24'h0);
        chk({o_wr_block, o_wr_index, o_wr_data}, {2'h1, 4'h9, 24'h000123});
        lf({SPACE_REG, 6'h19, RW_READ, 24'h0}, 24'h000123);
        for (int b = 0; b < 4; b++) begin
            lf({SPACE_REG, b[1:0], 4'h5, RW_WRITE, 20'hA0000, b[3:0]}, 24'h0);
            chk({o_wr_block, o_wr_index}, {b[1:0], 4'h5});
            peek({b[1:0], 4'h5}, {20'hA0000, b[3:0]});
        end
        lf({SPACE_REG, GLOBAL_ADDR, RW_WRITE, 24'h00AB00}, 24'h000F00);
        chk(o_serial_clock_predivider, 8'hAB);
        lf({SPACE_REG, 6'h3E, RW_WRITE, 24'h000055}, 24'h0);
        chk(n_fx, 1);
        chk({o_fx_addr, o_fx_data}, {6'h3E, 24'h000055});
        peek(6'h3E, 24'h0);
        lf({SPACE_REG, 6'h3D, RW_WRITE, 24'h000077}, 24'h0);
        lf({SPACE_REG, 6'h3D, RW_READ, 24'h0}, 24'h0);
        axw(AXI_CTRL, 32'h2, RESP_OKAY);
        lf({SPACE_REG, 6'h01, RW_WRITE, 24'h000011}, 24'h0);
        peek(6'h01, 24'h0);
        axr(AXI_STATUS, 32'h0000AB95, RESP_OKAY);
        chk(n_wr, 6);
        conclude();
    end
    initial begin
        repeat (30000) @(posedge i_clk_sys);
        n_fail++;
        conclude();
    end
endmodule
